// ===== shared/sysctrl_pkg.sv
/*
  Constants for the subsystem system control register bank: offsets,
  field positions, reset values and the reset-cause bit layout.
  Assumes a 32-bit APB data path and byte addresses.
*/
package sysctrl_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CAUSE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PDOWN = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CLK = 12'h008;
  localparam int CAUSE_W = 6;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_DBG = 1;
  localparam int CAUSE_RSVD = 2;
  localparam int CAUSE_HOST = 3;
  localparam int CAUSE_SUB = 4;
  localparam int CAUSE_SUBINT = 5;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_MASK = 6'h3b;
  localparam logic PDOWN_RST = 1'h0;
  localparam int CLK_W = 18;
  localparam int CLK_AON_FORCE = 0;
  localparam int CLK_AON_DLY_LO = 1;
  localparam int CLK_CORE_FORCE = 9;
  localparam int CLK_CORE_DLY_LO = 10;
  localparam int DLY_W = 8;
  localparam logic [CLK_W-1:0] CLK_RST = 18'h03e1f;
endpackage

// ===== src/sticky_bit.sv
/*
  One sticky flag: hardware set, software clear by writing zero.
  Assumes set and clear are synchronous single-cycle strobes.
*/
`timescale 1ns/1ps
module sticky_bit (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_q
);
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_q <= 1'b0;
    end else if (i_set) begin
      // Set wins over a clear in the same cycle
      o_q <= 1'b1;
    end else if (i_clr) begin
      o_q <= 1'b0;
    end
  end
endmodule

// ===== src/subsystem_sysctrl_regs.sv
/*
  System control register bank behind an APB subordinate port:
  reset-cause log, power-down permit, clock force and entry delays.
  Assumes i_srst is the subsystem power-on reset and that the cause
  inputs are synchronous one-cycle or level requests on i_core_clk.
*/
`timescale 1ns/1ps
module subsystem_sysctrl_regs
  import sysctrl_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [sysctrl_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [sysctrl_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [sysctrl_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [sysctrl_pkg::CAUSE_W-1:0] i_cause_evt,
  output logic o_domain_powerdown_permit,
  output logic o_aon_clk_force,
  output logic [sysctrl_pkg::DLY_W-1:0] o_aon_entry_delay,
  output logic o_core_clk_force,
  output logic [sysctrl_pkg::DLY_W-1:0] o_core_entry_delay
);
  import sysctrl_pkg::*;

  logic setup_ph;
  logic wr_acc;
  logic rd_set;
  logic [DATA_W-1:0] wmask;
  logic [CAUSE_W-1:0] cause_q;
  logic [CAUSE_W-1:0] cause_clr;
  logic [CAUSE_W-1:0] cause_set;
  logic pdown_ff;
  logic [CLK_W-1:0] clk_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // Answer is ready in the access phase of every transfer
  assign setup_ph = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_set = setup_ph && !i_pwrite;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_pstrb[b]}};
    end
  end

  // Log clears only on zero written in an enabled lane
  assign cause_clr = (wr_acc && i_paddr == OFS_CAUSE) ?
    (~i_pwdata[CAUSE_W-1:0] & wmask[CAUSE_W-1:0] & CAUSE_MASK) :
    '0;
  assign cause_set = i_cause_evt & CAUSE_MASK;

  genvar g;
  generate
    for (g = 0; g < CAUSE_W; g++) begin : g_cause
      sticky_bit u_bit (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_set(cause_set[g]),
        .i_clr(cause_clr[g]),
        .o_q(cause_q[g])
      );
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pdown_ff <= PDOWN_RST;
    end else if (wr_acc && i_paddr == OFS_PDOWN && i_pstrb[0]) begin
      pdown_ff <= i_pwdata[0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      clk_ff <= CLK_RST;
    end else if (wr_acc && i_paddr == OFS_CLK) begin
      clk_ff <= (clk_ff & ~wmask[CLK_W-1:0]) |
        (i_pwdata[CLK_W-1:0] & wmask[CLK_W-1:0]);
    end
  end

  always_comb begin
    nxt_rdata = '0;
    case (i_paddr)
      OFS_CAUSE: nxt_rdata[CAUSE_W-1:0] = cause_q;
      OFS_PDOWN: nxt_rdata[0] = pdown_ff;
      OFS_CLK: nxt_rdata[CLK_W-1:0] = clk_ff;
      default: nxt_rdata = '0;
    endcase
  end

  // Read data captured in the setup phase, held through the access phase
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_prdata <= '0;
    end else if (rd_set) begin
      o_prdata <= nxt_rdata;
    end else if (setup_ph) begin
      o_prdata <= '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup_ph;
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_domain_powerdown_permit <= PDOWN_RST;
      o_aon_clk_force <= CLK_RST[CLK_AON_FORCE];
      o_aon_entry_delay <= CLK_RST[CLK_AON_DLY_LO +: DLY_W];
      o_core_clk_force <= CLK_RST[CLK_CORE_FORCE];
      o_core_entry_delay <= CLK_RST[CLK_CORE_DLY_LO +: DLY_W];
    end else begin
      o_domain_powerdown_permit <= pdown_ff;
      o_aon_clk_force <= clk_ff[CLK_AON_FORCE];
      o_aon_entry_delay <= clk_ff[CLK_AON_DLY_LO +: DLY_W];
      o_core_clk_force <= clk_ff[CLK_CORE_FORCE];
      o_core_entry_delay <= clk_ff[CLK_CORE_DLY_LO +: DLY_W];
    end
  end

  // Assertions
  sequence setup_s;
    i_psel && !i_penable;
  endsequence

  sequence access_s;
    i_psel && i_penable;
  endsequence

  sequence rd_setup_s;
    i_psel && !i_penable && !i_pwrite;
  endsequence

  no_wait_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    setup_s ##1 access_s |-> o_pready)
    else $error("access phase without ready");

  no_error_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    !o_pslverr)
    else $error("error response signalled");

  unmapped_zero_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    rd_setup_s ##0 (i_paddr != OFS_CAUSE && i_paddr != OFS_PDOWN &&
    i_paddr != OFS_CLK) |=> o_prdata == '0)
    else $error("unmapped read not zero");

  clk_read_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    rd_setup_s ##0 (i_paddr == OFS_CLK) |=>
    o_prdata == {{(DATA_W-CLK_W){1'b0}}, $past(clk_ff)})
    else $error("clock register read wrong");

  rsvd_zero_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    o_prdata[DATA_W-1:CLK_W] == '0)
    else $error("reserved read bits not zero");

  clk_reset_a: assert property (@(posedge i_core_clk)
    $fell(i_srst) |-> clk_ff == CLK_RST && pdown_ff == PDOWN_RST &&
    cause_q == CAUSE_RST)
    else $error("register reset value wrong");

  // A logged cause may only drop when software clears it
  cause_sticky_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    cause_q != '0 |=>
    (($past(cause_q) & ~$past(cause_clr)) & ~cause_q) == '0)
    else $error("logged cause lost");

  cause_set_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    cause_set != '0 |=> (cause_q & $past(cause_set)) == $past(cause_set))
    else $error("reset cause not logged");

  cause_clear_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    cause_clr != '0 |=>
    (cause_q & $past(cause_clr) & ~$past(cause_set)) == '0)
    else $error("zero write did not clear cause");

  cause_keep_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    wr_acc && i_paddr == OFS_CAUSE && i_pwdata[CAUSE_SUB] &&
    cause_q[CAUSE_SUB] |=> cause_q[CAUSE_SUB])
    else $error("one write changed cause");

  rsvd_cause_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    !cause_q[CAUSE_RSVD])
    else $error("reserved cause bit set");

  permit_out_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    wr_acc && i_paddr == OFS_PDOWN && i_pstrb[0] |=>
    ##1 o_domain_powerdown_permit == $past(i_pwdata[0], 2))
    else $error("permit output not following write");

  aon_out_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    ##1 o_aon_clk_force == $past(clk_ff[CLK_AON_FORCE]) &&
    o_aon_entry_delay == $past(clk_ff[CLK_AON_DLY_LO +: DLY_W]))
    else $error("always-on clock output mismatch");

  core_force_a: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    ##1 o_core_clk_force == $past(clk_ff[CLK_CORE_FORCE]) &&
    o_core_entry_delay == $past(clk_ff[CLK_CORE_DLY_LO +: DLY_W]))
    else $error("core force output mismatch");
endmodule

// ===== tb/apb_manager_model.sv
/*
  APB manager model that issues single transfers to the register bank.
  Assumes calls start just after a rising clock edge.
*/
`timescale 1ns/1ps
module apb_manager_model (
  input wire logic i_core_clk,
  input wire logic [sysctrl_pkg::DATA_W-1:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [sysctrl_pkg::ADDR_W-1:0] o_paddr,
  output logic [sysctrl_pkg::DATA_W-1:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  import sysctrl_pkg::*;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
    o_pstrb = 4'hf;
  end
  // Ok is set only for a zero-wait answer without an error
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q,
    output logic ok);
    int n;
    o_psel = 1'b1;
    o_pstrb = s;
    o_pwrite = wr;
    o_paddr = a;
    o_pwdata = d;
    @(posedge i_core_clk);
    #1 o_penable = 1'b1;
    for (n = 0; n < 4; n++) begin
      @(posedge i_core_clk);
      if (i_pready === 1'b1) break;
    end
    ok = (n == 0) && (i_pslverr === 1'b0);
    q = i_prdata;
    #1 o_psel = 1'b0;
    o_penable = 1'b0;
    // Released lines show no stale value
    o_paddr = ~a;
    o_pwdata = ~d;
    @(posedge i_core_clk);
    #1;
  endtask
endmodule

// ===== tb/subsystem_sysctrl_regs_bench.sv
/*
  Self-checking bench for the system control register bank.
  Assumes a 125 MHz clock and the APB manager model as partner.
*/
`timescale 1ns/1ps
module subsystem_sysctrl_regs_bench;
  import sysctrl_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic permit, aon_f, core_f;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] cause;
  logic [7:0] aon_d, core_d;
  logic [31:0] outs;
  assign outs = {13'h0, permit, core_d, core_f, aon_d, aon_f};
  int err_count, checked;
  apb_manager_model mgr (.i_core_clk(clk), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .o_pstrb(pstrb));
  subsystem_sysctrl_regs dut (.i_core_clk(clk), .i_srst(srst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cause_evt(cause), .o_domain_powerdown_permit(permit),
    .o_aon_clk_force(aon_f), .o_aon_entry_delay(aon_d),
    .o_core_clk_force(core_f), .o_core_entry_delay(core_d));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc_s(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [31:0] e);
    logic [31:0] q;
    logic ok;
    mgr.xfer(wr, a, d, s, q, ok);
    chk({31'h0, ok}, 32'h1);
    if (!wr) chk(q, e);
  endtask
  task automatic acc(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] e);
    acc_s(wr, a, d, 4'hf, e);
  endtask
  task automatic t_reset;
    acc(1'b0, OFS_CAUSE, 32'h0, 32'h0);
    acc(1'b0, OFS_PDOWN, 32'h0, 32'h0);
    acc(1'b0, OFS_CLK, 32'h0, 32'h3e1f);
    chk(outs, 32'h3e1f);
  endtask
  task automatic t_cause;
    cause = 6'h3f;
    @(posedge clk);
    #1 cause = 6'h00;
    acc(1'b0, OFS_CAUSE, 32'h0, 32'h3b);
    acc(1'b1, OFS_CAUSE, 32'hffff_fff6, 32'h0);
    acc(1'b0, OFS_CAUSE, 32'h0, 32'h32);
    acc(1'b1, OFS_CAUSE, 32'h0, 32'h0);
    acc(1'b0, OFS_CAUSE, 32'h0, 32'h0);
  endtask
  task automatic t_ctrl;
    acc(1'b1, OFS_PDOWN, 32'hffff_ffff, 32'h0);
    acc(1'b1, OFS_CLK, 32'hffff_ffff, 32'h0);
    acc(1'b0, OFS_PDOWN, 32'h0, 32'h1);
    acc(1'b0, OFS_CLK, 32'h0, 32'h3ffff);
    chk(outs, 32'h7ffff);
    acc(1'b1, OFS_CLK, 32'h0002_a554, 32'h0);
    acc(1'b0, OFS_CLK, 32'h0, 32'h2a554);
    chk(outs, 32'h6a554);
  endtask
  task automatic t_unmapped;
    acc(1'b1, 12'h00c, 32'hffff_ffff, 32'h0);
    acc(1'b0, 12'h00c, 32'h0, 32'h0);
    acc(1'b0, 12'h100, 32'h0, 32'h0);
    acc(1'b0, 12'hffc, 32'h0, 32'h0);
    acc(1'b0, OFS_CLK, 32'h0, 32'h2a554);
    acc(1'b0, OFS_PDOWN, 32'h0, 32'h1);
  endtask
  // Byte strobes: only enabled lanes change
  task automatic t_strobe;
    acc_s(1'b1, OFS_CLK, 32'h0, 4'h2, 32'h0);
    acc(1'b0, OFS_CLK, 32'h0, 32'h20054);
    acc_s(1'b1, OFS_PDOWN, 32'h0, 4'he, 32'h0);
    acc(1'b0, OFS_PDOWN, 32'h0, 32'h1);
    chk(outs, 32'h60054);
  endtask
  task automatic conclude;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    cause = 6'h00;
    err_count = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    t_reset();
    t_cause();
    t_ctrl();
    t_unmapped();
    t_strobe();
    cause = 6'h10;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    cause = 6'h00;
    t_reset();
    conclude();
  end
  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule
